// [src/spi_port_map.vh]
`ifndef SPI_PORT_MAP_VH
`define SPI_PORT_MAP_VH
// ----------------------------------------------------------------------------
// Register addresses (byte offsets on the local CPU access port)
// ----------------------------------------------------------------------------
`define SERIAL_DATA_ADDR     2'h0
`define SERIAL_CONTROL_ADDR  2'h1
`define SERIAL_CSTAT_ADDR    2'h2
// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define CR_IRQ_EN_BIT        7
`define CR_PORT_EN_BIT       6
`define CR_MASTER_BIT        4
`define CR_POL_BIT           3
`define CR_PHASE_BIT         2
// ----------------------------------------------------------------------------
// Control/status register fields
// ----------------------------------------------------------------------------
`define CS_DONE_BIT          7
`define CS_WRITE_COLLISION_FLAG_BIT          6
`define CS_OVR_BIT           5
`define CS_MODE_FAULT_FLAG_BIT          4
`define CS_SSM_BIT           1
`define CS_SSI_BIT           0
`define CS_RATE_MSB          4
`define CS_RATE_LSB          2
// ----------------------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------------------
`define CONTROL_RESET        8'h00
`define CSTAT_RESET          8'h00
`define BITS_PER_BYTE        4'h8
`define HALF_DIV_MIN         8'h02
`endif

// [src/spi_clock_divider.v]
`timescale 1ns/10ps
// ----------------------------------------------------------------------------
// Master clock generator: emits a one-cycle tick at each serial clock half.
// ----------------------------------------------------------------------------
`include "spi_port_map.vh"
module spi_clock_divider (
  input  wire       clk_i,
  input  wire       rstn_i,
  input  wire       run_i,
  input  wire [2:0] rate_i,
  output reg        tick_o
);
  reg  [7:0] count_reg;   // Cycles counted within the current half period.
  reg  [7:0] half_len;    // Half-period length selected by the rate field.

  // Six rates; half of f/4 is 2 cycles, the two top codes repeat the slowest.
  always @* begin
    case (rate_i)
      3'h0:    half_len = `HALF_DIV_MIN;
      3'h1:    half_len = 8'h04;
      3'h2:    half_len = 8'h08;
      3'h3:    half_len = 8'h10;
      3'h4:    half_len = 8'h20;
      default: half_len = 8'h40;
    endcase
  end

  // Counter restarts whenever no transfer runs, so each byte starts aligned.
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      count_reg <= 8'h00;
      tick_o    <= 1'b0;
    end else if (!run_i) begin
      count_reg <= 8'h00;
      tick_o    <= 1'b0;
    end else if (count_reg == half_len - 8'h01) begin
      count_reg <= 8'h00;
      tick_o    <= 1'b1;
    end else begin
      count_reg <= count_reg + 8'h01;
      tick_o    <= 1'b0;
    end
  end
endmodule // spi_clock_divider

// [src/spi_master_slave_port.v]
// Contract
// - Master data write shifts out MSB first.
// - Master starts; full duplex on one clock.
// - Six master rates, fastest f/4.
// - Soft select bit overrides select pin.
// - Phase selects first or second edge.
// - Phase-0 select high between bytes.
// - Master drives clock, idle equals polarity.
// - Master/enable held only while select high.
// - Only data write starts master transfer.
// - Done flag sets; interrupt when enabled.
// - Master clears done: status, data read.
// - Data writes blocked while done set and status not yet accessed.
// - Slave shifts MISO on external clock.
// - Slave clears done: status, data access.
// - Four timings; both ends match.
// - Master select-low sets mode fault.
// - Overrun sets; status read clears.
// - Write during transfer sets collision.
`timescale 1ns/10ps
`include "spi_port_map.vh"
module spi_master_slave_port (
  input  wire       clk_i,
  input  wire       rstn_i,
  input  wire [1:0] addr_i,        // Register select.
  input  wire       wr_i,          // One-cycle write strobe.
  input  wire       rd_i,          // One-cycle read strobe.
  input  wire [7:0] wdata_i,       // Write data.
  input  wire       cpu_irq_mask_i,// CPU interrupt mask, high masks.
  input  wire       sck_i,         // Serial clock pin level.
  input  wire       mosi_i,        // Master-out pin level.
  input  wire       miso_i,        // Master-in pin level.
  input  wire       ss_n_i,        // Slave select pin, active low.
  output reg  [7:0] rdata_o,       // Read data, valid the cycle after rd_i.
  output reg        irq_o,         // Interrupt request.
  output reg        sck_o,
  output reg        sck_oe_o,
  output reg        mosi_o,
  output reg        mosi_oe_o,
  output reg        miso_o,
  output reg        miso_oe_o
);
  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  reg  [7:0] serial_control_reg;     // Irq enable, port enable, role, timing.
  reg  [7:0] serial_ctrl_status_reg; // Rate and select handling bits.
  reg  [7:0] serial_data_reg;        // Receive buffer read through data.
  reg  [7:0] shift_reg;              // Transmit/receive shift register.
  reg  [3:0] bit_cnt_reg;            // Bits left to latch.
  reg        busy_reg;               // A byte is in flight.
  reg        transfer_done_flag;
  reg        write_collision_flag;
  reg        overrun_flag;
  reg        mode_fault_flag;
  reg        done_seen_reg;          // Status accessed while done flag was set.
  reg        write_collision_flag_seen_reg;          // Status accessed while collision was set.
  reg        mode_fault_flag_seen_reg;          // Status read while fault was set.
  reg        sck_prev_reg;           // Last sampled serial clock.
  reg        ss_prev_reg;            // Last internal select level.
  reg        edge_ph_reg;            // Master: next half is the second edge.
  reg        sample_bit_reg;         // Bit latched, shifted on next edge.
  wire       tick;                   // Master half-period tick.

  wire port_enable     = serial_control_reg[`CR_PORT_EN_BIT];
  wire master_select   = serial_control_reg[`CR_MASTER_BIT];
  wire port_irq_enable = serial_control_reg[`CR_IRQ_EN_BIT];
  wire clock_polarity  = serial_control_reg[`CR_POL_BIT];
  wire clock_phase     = serial_control_reg[`CR_PHASE_BIT];
  wire soft_select_manage = serial_ctrl_status_reg[`CS_SSM_BIT];
  wire soft_select_level  = serial_ctrl_status_reg[`CS_SSI_BIT];
  wire [2:0] clock_rate_sel =
    serial_ctrl_status_reg[`CS_RATE_MSB:`CS_RATE_LSB];

  // Internal select: the software level replaces the pin when managed.
  wire ss_int = soft_select_manage ? soft_select_level : ss_n_i;
  wire is_master = port_enable & master_select;
  wire is_slave  = port_enable & ~master_select & ~ss_int;

  // Access decode.
  wire wr_data = wr_i && (addr_i == `SERIAL_DATA_ADDR);
  wire rd_data = rd_i && (addr_i == `SERIAL_DATA_ADDR);
  wire wr_ctrl = wr_i && (addr_i == `SERIAL_CONTROL_ADDR);
  wire wr_cs   = wr_i && (addr_i == `SERIAL_CSTAT_ADDR);
  wire rd_cs   = rd_i && (addr_i == `SERIAL_CSTAT_ADDR);
  wire cs_acc  = wr_cs | rd_cs;

  // --------------------------------------------------------------------------
  // Slave clock edge detection; pins are synchronous to clk_i.
  // --------------------------------------------------------------------------
  wire sck_norm   = sck_i ^ clock_polarity;         // High during active half.
  wire lead_edge  = sck_norm & ~sck_prev_reg;       // First edge of a bit.
  wire trail_edge = ~sck_norm & sck_prev_reg;       // Second edge of a bit.

  // Master: even tick = first edge, odd tick = second edge.
  wire m_lead  = is_master & busy_reg & tick & ~edge_ph_reg;
  wire m_trail = is_master & busy_reg & tick & edge_ph_reg;
  wire s_lead  = is_slave & lead_edge;
  wire s_trail = is_slave & trail_edge;
  wire any_lead  = m_lead | s_lead;
  wire any_trail = m_trail | s_trail;
  // Latch on first edge with phase 0, on second edge with phase 1.
  wire latch_now = clock_phase ? any_trail : any_lead;
  wire shift_now = clock_phase ? any_lead  : any_trail;
  wire in_bit    = is_master ? miso_i : mosi_i;
  wire last_bit  = latch_now && (bit_cnt_reg == 4'h1);
  // Only edges inside a byte move the shifter. The first shift-side edge
  // of phase 1 keeps the MSB on the line, and so does the closing phase-0 edge.
  wire mid_byte  = (bit_cnt_reg != 4'h0) && (bit_cnt_reg != `BITS_PER_BYTE);
  // A phase-0 master still owes the last trailing edge after its eighth sample.
  wire hold_tail = is_master & ~clock_phase;

  // Divider runs only while a master byte is in flight.
  spi_clock_divider u_div (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .run_i  (is_master & busy_reg),
    .rate_i (clock_rate_sel),
    .tick_o (tick)
  );

  // Writes to data are refused while done is set and status not yet accessed.
  wire data_blocked = transfer_done_flag & ~done_seen_reg;
  wire collide = wr_data & busy_reg;
  // Phase-0 slave with select still low counts as mid-transfer.
  wire slave_ph0_low = port_enable & ~master_select & ~clock_phase & ~ss_int
                       & ss_prev_reg == 1'b0 & bit_cnt_reg == 4'h0
                       & transfer_done_flag;
  wire load_ok = wr_data & ~busy_reg & ~data_blocked & ~slave_ph0_low;
  // Internal select low while in master role is a fault.
  wire fault = is_master & ~ss_int;

  // --------------------------------------------------------------------------
  // Control registers, including the fault clearing sequence.
  // --------------------------------------------------------------------------
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      serial_control_reg     <= `CONTROL_RESET;
      serial_ctrl_status_reg <= `CSTAT_RESET;
    end else begin
      if (wr_cs) begin
        serial_ctrl_status_reg <= wdata_i;
      end
      if (fault) begin
        // Fault drops both role and enable; it wins over a same-cycle write.
        serial_control_reg[`CR_PORT_EN_BIT] <= 1'b0;
        serial_control_reg[`CR_MASTER_BIT]  <= 1'b0;
      end else if (wr_ctrl) begin
        serial_control_reg <= wdata_i;
        // Enable and role cannot be set while a fault is pending, except
        // as the closing write of the clearing sequence.
        if (mode_fault_flag && !mode_fault_flag_seen_reg) begin
          serial_control_reg[`CR_PORT_EN_BIT] <= 1'b0;
          serial_control_reg[`CR_MASTER_BIT]  <= 1'b0;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Shift engine: load, latch, shift, byte end.
  // --------------------------------------------------------------------------
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      shift_reg       <= 8'h00;
      bit_cnt_reg     <= 4'h0;
      busy_reg        <= 1'b0;
      edge_ph_reg     <= 1'b0;
      sample_bit_reg  <= 1'b0;
      serial_data_reg <= 8'h00;
    end else begin
      if (!port_enable) begin
        busy_reg    <= 1'b0;
        bit_cnt_reg <= 4'h0;
        edge_ph_reg <= 1'b0;
      end else if (load_ok) begin
        shift_reg   <= wdata_i;
        busy_reg    <= master_select;
        bit_cnt_reg <= `BITS_PER_BYTE;
        edge_ph_reg <= 1'b0;
      end else begin
        if (m_lead | m_trail) begin
          edge_ph_reg <= ~edge_ph_reg;
        end
        if (s_lead && !busy_reg) begin
          // Slave byte starts on its leading edge; a loaded count is kept.
          // Limitation: a phase-0 byte with nothing loaded loses its first sample.
          busy_reg <= 1'b1;
          if (bit_cnt_reg == 4'h0) begin
            bit_cnt_reg <= `BITS_PER_BYTE;
          end
        end
        if (latch_now && bit_cnt_reg != 4'h0) begin
          sample_bit_reg <= in_bit;
          bit_cnt_reg    <= bit_cnt_reg - 4'h1;
        end
        if (shift_now && busy_reg && mid_byte) begin
          shift_reg <= {shift_reg[6:0], sample_bit_reg};
        end
        if (last_bit) begin
          // Received byte is the seven shifted bits plus this last sample.
          serial_data_reg <= {shift_reg[6:0], in_bit};
          if (!hold_tail) begin
            busy_reg    <= 1'b0;
            edge_ph_reg <= 1'b0;
          end
          if (clock_phase == 1'b0) begin
            shift_reg <= {shift_reg[6:0], in_bit};
          end
        end
        if (m_trail && bit_cnt_reg == 4'h0) begin
          // Phase-0 master ends on its own trailing edge, keeping the half period.
          busy_reg <= 1'b0;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Status flags. Hardware set always wins over a same-cycle clear.
  // --------------------------------------------------------------------------
  wire done_clear = done_seen_reg &
                    (master_select ? rd_data : (rd_data | wr_data));
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      transfer_done_flag   <= 1'b0;
      write_collision_flag <= 1'b0;
      overrun_flag         <= 1'b0;
      mode_fault_flag      <= 1'b0;
      done_seen_reg        <= 1'b0;
      write_collision_flag_seen_reg        <= 1'b0;
      mode_fault_flag_seen_reg        <= 1'b0;
      ss_prev_reg          <= 1'b1;
      sck_prev_reg         <= 1'b0;
    end else begin
      sck_prev_reg <= sck_norm;
      ss_prev_reg  <= ss_int;
      // Status access while set arms the done and collision sequences; fault needs a status read.
      if (cs_acc && transfer_done_flag) begin
        done_seen_reg <= 1'b1;
      end else if (done_clear || !transfer_done_flag) begin
        done_seen_reg <= 1'b0;
      end
      if (cs_acc && write_collision_flag) begin
        write_collision_flag_seen_reg <= 1'b1;
      end else if (!write_collision_flag) begin
        write_collision_flag_seen_reg <= 1'b0;
      end
      if (rd_cs && mode_fault_flag) begin
        mode_fault_flag_seen_reg <= 1'b1;
      end else if (!mode_fault_flag) begin
        mode_fault_flag_seen_reg <= 1'b0;
      end
      if (last_bit) begin
        transfer_done_flag <= 1'b1;
        if (transfer_done_flag && !done_clear) begin
          overrun_flag <= 1'b1;
        end
      end else if (done_clear) begin
        transfer_done_flag <= 1'b0;
      end
      if (rd_cs && !(last_bit && transfer_done_flag)) begin
        overrun_flag <= 1'b0;
      end
      if (collide || (wr_data && slave_ph0_low)) begin
        write_collision_flag <= 1'b1;
      end else if (write_collision_flag_seen_reg && (rd_data || wr_data)) begin
        write_collision_flag <= 1'b0;
      end
      if (fault) begin
        mode_fault_flag <= 1'b1;
      end else if (mode_fault_flag_seen_reg && wr_ctrl) begin
        mode_fault_flag <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Outputs, all registered. Collision never raises an interrupt.
  // --------------------------------------------------------------------------
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o   <= 8'h00;
      irq_o     <= 1'b0;
      sck_o     <= 1'b0;
      sck_oe_o  <= 1'b0;
      mosi_o    <= 1'b0;
      mosi_oe_o <= 1'b0;
      miso_o    <= 1'b0;
      miso_oe_o <= 1'b0;
    end else begin
      irq_o <= port_irq_enable & ~cpu_irq_mask_i &
               (transfer_done_flag | mode_fault_flag | overrun_flag);
      case (addr_i)
        `SERIAL_DATA_ADDR:    rdata_o <= serial_data_reg;
        `SERIAL_CONTROL_ADDR: rdata_o <= serial_control_reg;
        `SERIAL_CSTAT_ADDR:   rdata_o <= {transfer_done_flag, write_collision_flag,
                                          overrun_flag, mode_fault_flag,
                                          serial_ctrl_status_reg[3:0]};
        default:              rdata_o <= 8'h00;
      endcase
      // Master drives clock; idle level equals polarity.
      sck_oe_o  <= is_master;
      sck_o     <= clock_polarity ^ (busy_reg & is_master & edge_ph_reg);
      if (tick && is_master && busy_reg) begin
        sck_o <= clock_polarity ^ ~edge_ph_reg;
      end
      mosi_oe_o <= is_master;
      mosi_o    <= shift_reg[7];
      miso_oe_o <= is_slave;
      miso_o    <= shift_reg[7];
    end
  end
endmodule // spi_master_slave_port

// [verification/spi_port_props.sv]
`timescale 1ns/10ps
// ----------------------------------------------------------------------------
// Port-level checks of the serial port.
// ----------------------------------------------------------------------------
module spi_port_props (
  input wire       clk_i,
  input wire       rstn_i,
  input wire [1:0] addr_i,
  input wire       wr_i,
  input wire       rd_i,
  input wire [7:0] wdata_i,
  input wire       cpu_irq_mask_i,
  input wire       ss_n_i,
  input wire [7:0] rdata_o,
  input wire       irq_o,
  input wire       sck_o,
  input wire       sck_oe_o,
  input wire       mosi_oe_o,
  input wire       miso_oe_o
);
  reg       ssm_reg;   // Soft select management as last written.
  reg       pol_reg;   // Polarity given with the last master enable.
  reg       par_reg;   // Parity of the driven clock toggles.
  reg       sck_reg;   // Clock pin one cycle back.
  reg       oe_reg;    // Clock enable one cycle back.
  reg [4:0] burst_reg; // Toggles since the last data write.
  // A toggle counts only while the clock was driven on both sides of it.
  wire      tog = sck_oe_o & oe_reg & (sck_o ^ sck_reg);
  // Polarity is taken only from enabling writes, so a disabling write
  // cannot shift the reference while the old level still stands.
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ssm_reg   <= 1'b0;
      pol_reg   <= 1'b0;
      par_reg   <= 1'b0;
      sck_reg   <= 1'b0;
      oe_reg    <= 1'b0;
      burst_reg <= 5'h00;
    end else begin
      if (wr_i && addr_i == 2'h2) ssm_reg <= wdata_i[1];
      if (wr_i && addr_i == 2'h1 && wdata_i[6] && wdata_i[4]) pol_reg <= wdata_i[3];
      sck_reg <= sck_o;
      oe_reg  <= sck_oe_o;
      par_reg <= par_reg ^ tog;
      if (wr_i && addr_i == 2'h0) burst_reg <= 5'h00;
      else if (tog) burst_reg <= burst_reg + 5'h01;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // Master driving its clock while the select pin is pulled low.
  sequence s_fault;
    !ssm_reg && sck_oe_o && !ss_n_i;
  endsequence
  // Pin-managed select held high for five cycles.
  sequence s_unsel;
    (!ssm_reg && ss_n_i) [*5];
  endsequence
  AST_HALF_MIN: assert property (tog |=> !tog)
    else $error("Serial clock half period shorter than two cycles.");
  AST_BURST: assert property (burst_reg <= 5'h10)
    else $error("More than sixteen clock halves for one data write.");
  AST_IDLE_POL: assert property (sck_oe_o && oe_reg && !(par_reg ^ tog) |-> sck_o == pol_reg)
    else $error("Idle serial clock differs from the polarity.");
  AST_IRQ_MASK: assert property (cpu_irq_mask_i |=> !irq_o)
    else $error("Interrupt raised while the CPU mask is set.");
  AST_ADDR3: assert property (rd_i && addr_i == 2'h3 |=> rdata_o == 8'h00)
    else $error("Unmapped address read is not zero.");
  AST_ROLE: assert property ((sck_oe_o || mosi_oe_o) |-> !miso_oe_o)
    else $error("Master and slave outputs driven together.");
  AST_FAULT: assert property (s_fault |-> ##[1:6] !sck_oe_o)
    else $error("Master kept driving with the select pin low.");
  AST_UNSEL: assert property (s_unsel |-> !miso_oe_o)
    else $error("Slave output driven while not selected.");
endmodule // spi_port_props
bind spi_master_slave_port spi_port_props spi_port_props_inst (
  .clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i),
  .wdata_i(wdata_i), .cpu_irq_mask_i(cpu_irq_mask_i), .ss_n_i(ss_n_i),
  .rdata_o(rdata_o), .irq_o(irq_o), .sck_o(sck_o), .sck_oe_o(sck_oe_o),
  .mosi_oe_o(mosi_oe_o), .miso_oe_o(miso_oe_o));

// [verification/spi_far_model.sv]
`timescale 1ns/10ps
// ----------------------------------------------------------------------------
// Far-side device: slave while the port masters, master while it is slave.
// ----------------------------------------------------------------------------
module spi_far_model (
  input  wire sck_i,           // Resolved clock wire.
  input  wire mosi_i,          // Resolved master-out wire.
  input  wire miso_i,          // Resolved master-in wire.
  input  wire mst_i,           // High while the port drives the clock.
  output reg  sck_o  = 1'b0,   // Clock when this side is master.
  output reg  mosi_o = 1'b0,   // Data when this side is master.
  output reg  miso_o = 1'b0,   // Data when this side is slave.
  output reg  ss_n_o = 1'b1    // Select, high while idle.
);
  reg       pol_reg = 1'b0;    // Agreed polarity.
  reg       pha_reg = 1'b0;    // Agreed phase.
  reg [7:0] sh_reg  = 8'h00;   // Slave transmit shifter.
  reg [7:0] rx_reg  = 8'h00;   // Slave receive shifter.
  integer   k;
  // Prepare a slave byte; phase 0 presents its first bit before any edge.
  task load(input [7:0] b, input p, input h);
    begin
      pol_reg = p;
      pha_reg = h;
      sck_o   = p;
      rx_reg  = 8'h00;
      sh_reg  = h ? b : {b[6:0], 1'b0};
      miso_o  = h ? ~miso_o : b[7];
    end
  endtask
  // Sample on the leading edge for phase 0 and the trailing one for phase 1.
  always @(sck_i) begin
    if (mst_i) begin
      if (sck_i == (pol_reg == pha_reg)) rx_reg = {rx_reg[6:0], mosi_i};
      else begin
        miso_o = sh_reg[7];
        sh_reg = {sh_reg[6:0], 1'b0};
      end
    end
  end
  // Master byte at six cycles a half, slower than half the CPU clock.
  // Select goes high after each byte so a phase 0 slave may reload.
  task xfer(input [7:0] b, input p, input h, output [7:0] got);
    begin
      ss_n_o = 1'b0;
      #300;
      for (k = 7; k >= 0; k = k - 1) begin
        if (h) sck_o = ~p;
        mosi_o = b[k];
        #150;
        got[k] = miso_i;
        sck_o = h ? p : ~p;
        #150;
        if (!h) sck_o = p;
      end
      mosi_o = ~mosi_o;
      #300;
      ss_n_o = 1'b1;
    end
  endtask
endmodule // spi_far_model

// [verification/testbench.sv]
`timescale 1ns/10ps
// ----------------------------------------------------------------------------
// Self-checking bench: master loop, mode fault, slave loop.
// ----------------------------------------------------------------------------
module testbench;
  reg        clk_i = 1'b0, rstn_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
  reg        cpu_irq_mask_i = 1'b0;   // CPU mask, high blocks requests.
  reg  [1:0] addr_i = 2'h0;           // Register select.
  reg  [7:0] wdata_i = 8'h00;         // Write data.
  reg  [7:0] d, tx, mx;               // Read value, port byte, far byte.
  reg  [31:0] seed = 32'h35EB0023;    // Random state.
  wire [7:0] rdata_o;
  wire       irq_o, sck_o, sck_oe_o, mosi_o, mosi_oe_o, miso_o, miso_oe_o;
  wire       f_sck, f_mosi, f_miso, f_ss_n;
  // Each wire carries whichever party enables its driver.
  wire       sck_w  = sck_oe_o ? sck_o : f_sck;
  wire       mosi_w = mosi_oe_o ? mosi_o : f_mosi;
  wire       miso_w = miso_oe_o ? miso_o : f_miso;
  integer    miscompares = 0, checked = 0, i, h;
  always #12.5 clk_i = ~clk_i;
  spi_master_slave_port spi_master_slave_port_inst (.clk_i(clk_i), .rstn_i(rstn_i),
    .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i), .wdata_i(wdata_i),
    .cpu_irq_mask_i(cpu_irq_mask_i), .sck_i(sck_w), .mosi_i(mosi_w), .miso_i(miso_w),
    .ss_n_i(f_ss_n), .rdata_o(rdata_o), .irq_o(irq_o), .sck_o(sck_o), .sck_oe_o(sck_oe_o),
    .mosi_o(mosi_o), .mosi_oe_o(mosi_oe_o), .miso_o(miso_o), .miso_oe_o(miso_oe_o));
  spi_far_model spi_far_model_inst (.sck_i(sck_w), .mosi_i(mosi_w), .miso_i(miso_w),
    .mst_i(sck_oe_o), .sck_o(f_sck), .mosi_o(f_mosi), .miso_o(f_miso), .ss_n_o(f_ss_n));
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Strobes rise and fall at falling edges, one cycle wide.
  task wr(input [1:0] a, input [7:0] v);
    begin
      @(negedge clk_i); addr_i = a; wdata_i = v; wr_i = 1'b1;
      @(negedge clk_i); wr_i = 1'b0;
    end
  endtask
  // Read data is taken one cycle after the strobe, before a reread can clear.
  task rd(input [1:0] a, output [7:0] v);
    begin
      @(negedge clk_i); addr_i = a; rd_i = 1'b1;
      @(negedge clk_i); rd_i = 1'b0; v = rdata_o;
    end
  endtask
  task chk8(input [7:0] g, input [7:0] e);
    begin
      checked = checked + 1;
      if (g !== e) begin
        miscompares = miscompares + 1;
        $display("Error at %0t: got %h, expected %h", $time, g, e);
      end
    end
  endtask
  task wrap_up;
    begin
      if (miscompares == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  // A hang counts as a mismatch.
  initial begin
    #1000000;
    miscompares = miscompares + 1;
    wrap_up;
  end
  initial begin
    repeat (20) @(negedge clk_i);
    rstn_i = 1'b1;
    rd(2'h2, d); chk8(d, 8'h00);
    rd(2'h1, d); chk8(d, 8'h00);
    rd(2'h3, d); chk8(d, 8'h00);
    // Master: all six rates and four timings; the select pin is held low,
    // which soft management must hide.
    spi_far_model_inst.ss_n_o = 1'b0;
    for (i = 0; i < 6; i = i + 1) begin
      h = 2 << i;
      seed = lfsr(seed); tx = seed[7:0];
      seed = lfsr(seed); mx = seed[7:0];
      wr(2'h2, {3'h0, i[2:0], 2'h3});
      spi_far_model_inst.load(mx, i[0], i[1]);
      wr(2'h1, {4'hD, i[0], i[1], 2'h0});
      cpu_irq_mask_i = (i == 1);
      wr(2'h0, tx);
      if (i == 3) begin
        repeat (4 * h) @(negedge clk_i);
        wr(2'h0, 8'hFF);
      end
      repeat (16 * h + 12) @(negedge clk_i);
      chk8(irq_o, i != 1);
      chk8(spi_far_model_inst.rx_reg, tx);
      if (i == 2) begin
        wr(2'h0, 8'h5A);
        repeat (8) @(negedge clk_i);
        chk8(sck_o, i[0]);
      end
      rd(2'h2, d); chk8(d, {1'b1, i == 3, 2'h0, i[1:0], 2'h3});
      if (i == 4) begin
        spi_far_model_inst.load(mx, i[0], i[1]);
        wr(2'h0, tx);
        repeat (16 * h + 12) @(negedge clk_i);
        rd(2'h2, d); chk8(d, {4'hA, i[1:0], 2'h3});
      end
      rd(2'h0, d);
      if (i != 4) chk8(d, mx);
      rd(2'h2, d); chk8(d, {4'h0, i[1:0], 2'h3});
      wr(2'h1, 8'h00);
    end
    cpu_irq_mask_i = 1'b0;
    // Mode fault: pin-managed select pulled low under an enabled master.
    spi_far_model_inst.ss_n_o = 1'b1;
    wr(2'h2, 8'h00);
    spi_far_model_inst.load(8'h00, 1'b0, 1'b0);
    wr(2'h1, 8'hD0);
    spi_far_model_inst.ss_n_o = 1'b0;
    repeat (8) @(negedge clk_i);
    spi_far_model_inst.ss_n_o = 1'b1;
    chk8(irq_o, 8'h01);
    rd(2'h2, d); chk8(d, 8'h10);
    rd(2'h1, d); chk8(d, 8'h80);
    wr(2'h1, 8'h00);
    rd(2'h2, d); chk8(d, 8'h00);
    // Slave: four timings; each reload by write clears the previous done.
    for (i = 0; i < 4; i = i + 1) begin
      wr(2'h1, 8'h00);
      spi_far_model_inst.sck_o = i[0];
      wr(2'h2, 8'h00);
      wr(2'h1, {4'hC, i[0], i[1], 2'h0});
      if (i > 0) begin
        rd(2'h2, d); chk8(d, 8'h80);
      end
      seed = lfsr(seed); tx = seed[7:0];
      seed = lfsr(seed); mx = seed[7:0];
      wr(2'h0, tx);
      rd(2'h2, d); chk8(d, 8'h00);
      spi_far_model_inst.xfer(mx, i[0], i[1], d);
      chk8(d, tx);
      rd(2'h0, d); chk8(d, mx);
    end
    wrap_up;
  end
endmodule // testbench
